/* hw/pmd_pkg.sv */
// constants, carriers and decode helpers for the pdm record decimation path
// assumes a single 10 MHz core clock and one design file that imports nothing
package pmd_pkg;
  localparam int unsigned DW         = 16;          // sample width
  localparam int unsigned IW         = 24;          // cic accumulator width
  localparam int unsigned AW         = 40;          // mac accumulator width
  localparam int unsigned COEF_FRAC  = 14;          // filter coefficients are q2.14
  localparam int unsigned GAIN_FRAC  = 15;          // fine gain is q1.15
  localparam int unsigned COEF_DEPTH = 64;
  localparam int unsigned BIQ_STRIDE = 5;           // b0 b1 b2 a1 a2 per biquad
  localparam logic [5:0]  COEF_IIR   = 6'h00;       // b0 b1 a1
  localparam logic [5:0]  COEF_BIQ   = 6'h03;       // five biquads, 25 words
  localparam logic [5:0]  COEF_FIR   = 6'h1C;       // up to 25 taps
  localparam logic [4:0]  BLK_MIN    = 5'h01;
  localparam logic [4:0]  BLK_MAX    = 5'h12;
  localparam logic [4:0]  BLK_RESET  = 5'h01;       // record_block_one
  localparam logic [1:0]  OSR_128    = 2'h0;
  localparam logic [1:0]  OSR_64     = 2'h1;
  localparam logic [1:0]  OSR_32     = 2'h2;
  localparam logic [1:0]  FILT_A     = 2'h0;
  localparam logic [1:0]  FILT_B     = 2'h1;
  localparam logic [1:0]  FILT_C     = 2'h2;
  localparam logic [2:0]  BIQ_AC     = 3'h5;
  localparam logic [2:0]  BIQ_B      = 3'h3;
  localparam logic [4:0]  TAP_AC     = 5'h19;       // 25 taps
  localparam logic [4:0]  TAP_B      = 5'h14;       // 20 taps
  localparam int unsigned TAP_MAX    = 25;
  localparam int unsigned BIQ_MAX    = 5;
  localparam logic signed [5:0] VOL_MIN = -6'sd12;  // dB
  localparam logic signed [5:0] VOL_MAX = 6'sd20;   // dB
  localparam logic [2:0]  FINE_MAX   = 3'h4;        // 0 .. -0.4 dB in 0.1 dB steps

  typedef struct packed {
    logic [1:0] filt;        // decimation filter variant
    logic       right_only;  // left channel not processed
    logic [2:0] nbiq;        // biquads in cascade
    logic [4:0] ntap;        // fir taps, zero when absent
  } pmd_blk_t;

  typedef struct packed {
    logic                 right;  // channel of this word
    logic signed [DW-1:0] data;
  } pmd_sample_t;

  // block number to configuration; out-of-range numbers fall back to block one
  function automatic pmd_blk_t pmd_decode(input logic [4:0] sel);
    logic [4:0] b;
    logic [4:0] grp;
    logic [4:0] idx;
    pmd_blk_t   r;
    b            = (sel < BLK_MIN || sel > BLK_MAX) ? BLK_RESET : sel;
    grp          = b - 5'h01;
    r.filt       = 2'(grp / 5'h06);
    idx          = grp % 5'h06;
    r.right_only = (idx >= 5'h03);
    idx          = idx % 5'h03;
    r.nbiq       = (idx == 5'h01) ? ((r.filt == FILT_B) ? BIQ_B : BIQ_AC) : 3'h0;
    r.ntap       = (idx == 5'h02) ? ((r.filt == FILT_B) ? TAP_B : TAP_AC) : 5'h00;
    return r;
  endfunction

  // legal oversampling ratio per filter variant
  function automatic logic pmd_osr_ok(input logic [1:0] filt, input logic [1:0] osr);
    case (filt)
      FILT_A:  return (osr == OSR_128) || (osr == OSR_64);
      FILT_B:  return (osr == OSR_64);
      FILT_C:  return (osr == OSR_32);
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic signed [DW-1:0] pmd_sat(input logic signed [AW-1:0] v);
    if (v > AW'(32767))
      return 16'sh7FFF;
    else if (v < -AW'(32768))
      return -16'sh8000;
    else
      return v[DW-1:0];
  endfunction
endpackage

/* hw/pmd_record.sv */
// stereo pdm microphone record path: cic decimation, iir, biquads or fir,
// fine gain, volume, mute and a two-entry output buffer.
// assumes pdm_tick is a same-clock strobe marking valid mic bits on the pins.

// Contract
// - decimate pdm bits to nyquist-rate samples
// - left and right powered independently
// - fine gain in 0.1 dB steps
// - volume from -12 to +20 dB
// - three decimation filter variants
// - block number selects filter and stages
// - osr per filter; eighteen blocks, one default
// - iir always, plus biquads, fir or neither
// - all filter coefficients user loaded
module pmd_record (
  input  wire logic                 core_clk,    // 10 MHz core clock
  input  wire logic                 rst,         // synchronous, active high
  input  wire logic                 ce,          // clock enable, freezes all state
  input  wire logic                 pdm_l,       // left mic data pin
  input  wire logic                 pdm_r,       // right mic data pin
  input  wire logic                 pdm_tick,    // mic bit strobe
  input  wire logic [4:0]           block_sel,   // processing block 1..18
  input  wire logic [1:0]           decimation_oversampling_ratio, // 128/64/32
  input  wire logic                 power_l,     // left channel on
  input  wire logic                 power_r,     // right channel on
  input  wire logic [2:0]           fine_l,      // left fine gain, -0.1 dB per step
  input  wire logic [2:0]           fine_r,      // right fine gain
  input  wire logic signed [5:0]    vol_l,       // left volume, dB
  input  wire logic signed [5:0]    vol_r,       // right volume, dB
  input  wire logic                 mute_l,      // left mute
  input  wire logic                 mute_r,      // right mute
  input  wire logic                 coef_we,     // coefficient write strobe
  input  wire logic [5:0]           coef_addr,   // coefficient word address
  input  wire logic signed [15:0]   coef_data,   // coefficient value
  output pmd_pkg::pmd_sample_t      out_word,    // sample and channel
  output logic                      out_valid,   // word available
  input  wire logic                 out_ready,   // receiver accepts
  output logic                      cfg_error    // osr illegal for chosen filter
);
  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_IIR = 6'h02, S_BIQ = 6'h04, S_FIR = 6'h08, S_GAIN = 6'h10, S_OUT = 6'h20
  } pmd_state_t;

  // block decode and oversampling setup
  wire pmd_pkg::pmd_blk_t blk     = pmd_pkg::pmd_decode(block_sel);
  wire logic [1:0]        order   = (blk.filt == pmd_pkg::FILT_A) ? 2'h3 :
                                    (blk.filt == pmd_pkg::FILT_B) ? 2'h2 : 2'h1;
  wire logic [2:0]        lg_osr  = (decimation_oversampling_ratio == pmd_pkg::OSR_128) ? 3'h7 :
                                    (decimation_oversampling_ratio == pmd_pkg::OSR_64) ? 3'h6 : 3'h5;
  wire logic [6:0]        osr_top = 7'((8'h01 << lg_osr) - 8'h01);
  wire logic [1:0]        ch_on   = {power_r, power_l & ~blk.right_only};

  logic [2:0]              sync_reg [2];
  logic [1:0]              bit_reg;
  logic [6:0]              tick_cnt_reg;
  logic signed [pmd_pkg::IW-1:0] integ_reg [2][3];
  logic signed [pmd_pkg::IW-1:0] dly_reg   [2][3];
  logic signed [15:0]      dec_reg [2];
  logic [1:0]              pend_reg;
  logic signed [15:0]      coef_mem [pmd_pkg::COEF_DEPTH];
  wire logic               decim = pdm_tick && (tick_cnt_reg == osr_top);
  wire logic signed [pmd_pkg::IW-1:0] comb_out [2];

  // three-flop pin capture; a bit counts once flops two and three agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_reg <= '{3'h0, 3'h0};
      bit_reg  <= 2'h0;
    end else if (ce) begin
      sync_reg[0] <= {sync_reg[0][1:0], pdm_l};
      sync_reg[1] <= {sync_reg[1][1:0], pdm_r};
      if (sync_reg[0][1] == sync_reg[0][2]) bit_reg[0] <= sync_reg[0][2];
      if (sync_reg[1][1] == sync_reg[1][2]) bit_reg[1] <= sync_reg[1][2];
    end
  end

  // cic per channel; order follows the filter variant, wrap arithmetic is safe
  for (genvar c = 0; c < 2; c++) begin : g_ch
    wire logic signed [pmd_pkg::IW-1:0] cx [4];
    assign cx[0] = integ_reg[c][order - 2'h1];
    for (genvar k = 0; k < 3; k++) begin : g_stage
      assign cx[k+1] = (k < order) ? cx[k] - dly_reg[c][k] : cx[k];
      always_ff @(posedge core_clk) begin
        if (rst) begin
          integ_reg[c][k] <= '0;
          dly_reg[c][k]   <= '0;
        end else if (ce) begin
          if (pdm_tick)
            integ_reg[c][k] <= integ_reg[c][k] + ((k == 0) ? (bit_reg[c] ? 24'sh000001 : -24'sh000001)
                                                           : integ_reg[c][(k > 0) ? k - 1 : 0]);
          if (decim) dly_reg[c][k] <= cx[k];
        end
      end
    end
    assign comb_out[c] = cx[3];
  end

  // scale cic gain of osr^order back to 16 bits
  wire logic [4:0] norm_sh = 5'(order * lg_osr);
  // concatenation is unsigned, so the sign is restored before the arithmetic shift
  wire logic signed [pmd_pkg::AW-1:0] norm_l = ($signed({{16{comb_out[0][23]}}, comb_out[0]}) <<< 15) >>> norm_sh;
  wire logic signed [pmd_pkg::AW-1:0] norm_r = ($signed({{16{comb_out[1][23]}}, comb_out[1]}) <<< 15) >>> norm_sh;

  // sequencer state and per-channel filter history
  pmd_state_t          st_reg;
  logic                ch_reg;
  logic [4:0]          idx_reg;
  logic signed [15:0]  x_reg;
  logic signed [15:0]  gain_reg;
  logic signed [pmd_pkg::AW-1:0] acc_reg;
  logic signed [15:0]  iir_x1 [2];
  logic signed [15:0]  iir_y1 [2];
  logic signed [15:0]  bq_x1 [2][pmd_pkg::BIQ_MAX];
  logic signed [15:0]  bq_x2 [2][pmd_pkg::BIQ_MAX];
  logic signed [15:0]  bq_y1 [2][pmd_pkg::BIQ_MAX];
  logic signed [15:0]  bq_y2 [2][pmd_pkg::BIQ_MAX];
  logic signed [15:0]  fir_d [2][pmd_pkg::TAP_MAX];
  wire logic           take    = (st_reg == S_IDLE) && (pend_reg != 2'h0);
  wire logic           take_ch = ~pend_reg[0];                   // left first
  wire logic [1:0]     take_v  = take ? (take_ch ? 2'h2 : 2'h1) : 2'h0;
  wire logic [1:0]     set_v   = decim ? ch_on : 2'h0;
  wire logic           buf_in_ready;

  // iir and current biquad stage, coefficients read straight from the store
  wire logic [5:0] bq_a = 6'(pmd_pkg::COEF_BIQ + 6'(idx_reg) * 6'(pmd_pkg::BIQ_STRIDE));
  wire logic signed [pmd_pkg::AW-1:0] iir_sum = coef_mem[pmd_pkg::COEF_IIR] * x_reg
    + coef_mem[pmd_pkg::COEF_IIR + 6'h1] * iir_x1[ch_reg] - coef_mem[pmd_pkg::COEF_IIR + 6'h2] * iir_y1[ch_reg];
  wire logic [2:0] bi = idx_reg[2:0];
  wire logic signed [pmd_pkg::AW-1:0] bq_sum = coef_mem[bq_a] * x_reg
    + coef_mem[bq_a + 6'h1] * bq_x1[ch_reg][bi] + coef_mem[bq_a + 6'h2] * bq_x2[ch_reg][bi]
    - coef_mem[bq_a + 6'h3] * bq_y1[ch_reg][bi] - coef_mem[bq_a + 6'h4] * bq_y2[ch_reg][bi];
  wire logic signed [15:0] iir_y = pmd_pkg::pmd_sat(iir_sum >>> pmd_pkg::COEF_FRAC);
  wire logic signed [15:0] bq_y  = pmd_pkg::pmd_sat(bq_sum >>> pmd_pkg::COEF_FRAC);
  wire logic signed [pmd_pkg::AW-1:0] fir_acc = acc_reg + coef_mem[pmd_pkg::COEF_FIR + 6'(idx_reg)] * fir_d[ch_reg][idx_reg];

  // gain: fine step table, then volume as octave shift times a 1 dB step table
  wire logic [2:0]        fine_c = ch_reg ? fine_r : fine_l;
  wire logic [2:0]        fine_k = (fine_c > pmd_pkg::FINE_MAX) ? pmd_pkg::FINE_MAX : fine_c;
  wire logic signed [5:0] vol_c  = ch_reg ? vol_r : vol_l;
  wire logic signed [5:0] vol_k  = (vol_c < pmd_pkg::VOL_MIN) ? pmd_pkg::VOL_MIN :
                                   (vol_c > pmd_pkg::VOL_MAX) ? pmd_pkg::VOL_MAX : vol_c;
  wire logic [5:0]        vol_u  = 6'(vol_k - pmd_pkg::VOL_MIN);
  wire logic [2:0]        vol_oct = 3'(vol_u / 6'h06);
  wire logic [2:0]        vol_fr  = 3'(vol_u % 6'h06);
  wire logic signed [17:0] fine_m = (fine_k == 3'h0) ? 18'sh08000 : (fine_k == 3'h1) ? 18'sh07E89 :
                                    (fine_k == 3'h2) ? 18'sh07D16 : (fine_k == 3'h3) ? 18'sh07BA8 : 18'sh07A3D;
  wire logic signed [17:0] vol_m  = (vol_fr == 3'h0) ? 18'sh04000 : (vol_fr == 3'h1) ? 18'sh047CF :
                                    (vol_fr == 3'h2) ? 18'sh05092 : (vol_fr == 3'h3) ? 18'sh05A67 :
                                    (vol_fr == 3'h4) ? 18'sh0656F : 18'sh071CF;
  wire logic signed [pmd_pkg::AW-1:0] fine_p = (x_reg * fine_m) >>> pmd_pkg::GAIN_FRAC;
  wire logic signed [pmd_pkg::AW-1:0] vol_p  = ((fine_p * vol_m) <<< vol_oct) >>> 16;    // 6 dB taken as 2x
  wire logic              mute_c = ch_reg ? mute_r : mute_l;

  // sample capture, pending flags (a new sample beats the take) and store writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tick_cnt_reg <= 7'h00;
      dec_reg      <= '{16'sh0000, 16'sh0000};
      pend_reg     <= 2'h0;
      cfg_error    <= 1'b0;
    end else if (ce) begin
      if (pdm_tick) tick_cnt_reg <= decim ? 7'h00 : 7'(tick_cnt_reg + 7'h01);
      if (decim) dec_reg <= '{pmd_pkg::pmd_sat(norm_l), pmd_pkg::pmd_sat(norm_r)};
      pend_reg  <= ((pend_reg & ~take_v) | set_v) & ch_on;
      cfg_error <= ~pmd_pkg::pmd_osr_ok(blk.filt, decimation_oversampling_ratio);
    end
  end

  always_ff @(posedge core_clk) begin
    if (ce && coef_we) coef_mem[coef_addr] <= coef_data;
  end

  // per-sample sequencer, one stage or tap per cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= S_IDLE; ch_reg <= 1'b0; idx_reg <= 5'h00; x_reg <= '0; gain_reg <= '0; acc_reg <= '0;
      iir_x1 <= '{default: '0}; iir_y1 <= '{default: '0};
      bq_x1  <= '{default: '{default: '0}}; bq_x2 <= '{default: '{default: '0}};
      bq_y1  <= '{default: '{default: '0}}; bq_y2 <= '{default: '{default: '0}};
      fir_d  <= '{default: '{default: '0}};
    end else if (ce) begin
      case (st_reg)
        S_IDLE: if (take) begin
          ch_reg <= take_ch; x_reg <= dec_reg[take_ch]; st_reg <= S_IIR;
        end
        S_IIR: begin
          iir_x1[ch_reg] <= x_reg; iir_y1[ch_reg] <= iir_y; x_reg <= iir_y; idx_reg <= 5'h00; acc_reg <= '0;
          if (blk.nbiq != 3'h0) st_reg <= S_BIQ;
          else if (blk.ntap != 5'h00) begin
            fir_d[ch_reg] <= {iir_y, fir_d[ch_reg][0:pmd_pkg::TAP_MAX-2]}; st_reg <= S_FIR;
          end else st_reg <= S_GAIN;
        end
        S_BIQ: begin
          bq_x2[ch_reg][bi] <= bq_x1[ch_reg][bi]; bq_x1[ch_reg][bi] <= x_reg;
          bq_y2[ch_reg][bi] <= bq_y1[ch_reg][bi]; bq_y1[ch_reg][bi] <= bq_y; x_reg <= bq_y;
          idx_reg <= 5'(idx_reg + 5'h01);
          if (bi == blk.nbiq - 3'h1) st_reg <= S_GAIN;
        end
        S_FIR: begin
          acc_reg <= fir_acc; idx_reg <= 5'(idx_reg + 5'h01);
          if (idx_reg == blk.ntap - 5'h01) begin
            x_reg <= pmd_pkg::pmd_sat(fir_acc >>> pmd_pkg::COEF_FRAC); st_reg <= S_GAIN;
          end
        end
        S_GAIN: begin
          gain_reg <= mute_c ? 16'sh0000 : pmd_pkg::pmd_sat(vol_p);
          st_reg   <= S_OUT;
        end
        S_OUT: if (buf_in_ready) st_reg <= S_IDLE;                                      // stall holds the word
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // two-entry buffer; a full buffer holds the sequencer in S_OUT
  pmd_pkg::pmd_sample_t buf_mem [2];
  logic [1:0] cnt_reg;
  logic       wr_reg;
  logic       rd_reg;
  wire logic  push = (st_reg == S_OUT) && buf_in_ready;
  wire logic  pop  = out_valid && out_ready;
  assign buf_in_ready = (cnt_reg != 2'h2);
  assign out_valid    = (cnt_reg != 2'h0);
  assign out_word     = buf_mem[rd_reg];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg <= 2'h0; wr_reg <= 1'b0; rd_reg <= 1'b0; buf_mem <= '{default: '0};
    end else if (ce) begin
      if (push) begin
        buf_mem[wr_reg] <= '{right: ch_reg, data: gain_reg}; wr_reg <= ~wr_reg;
      end
      if (pop) rd_reg <= ~rd_reg;
      cnt_reg <= 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst || !ce);
  dec_spacing_a: assert property (decim |=> !decim [*8]) else $error("decimation strobes too close");
  chan_power_a: assert property (!ch_on[0] |=> !pend_reg[0]) else $error("unpowered left channel pending");
  fine_unity_a: assert property (st_reg == S_GAIN && fine_k == 3'h0 && vol_k == 6'sd0 && !mute_c
    |=> gain_reg == $past(x_reg)) else $error("unity gain altered sample");
  vol_clamp_a: assert property (vol_k >= -6'sd12 && vol_k <= 6'sd20) else $error("volume outside range");
  filt_order_a: assert property (blk.filt == pmd_pkg::FILT_C |-> order == 2'h1) else $error("filter c order wrong");
  blk_default_a: assert property (block_sel > 5'h12 |-> blk == pmd_pkg::pmd_decode(5'h01))
    else $error("bad block not defaulted");
  osr_check_a: assert property (blk.filt == pmd_pkg::FILT_B && decimation_oversampling_ratio != pmd_pkg::OSR_64
    |=> cfg_error) else $error("osr error not flagged");
  stage_mix_a: assert property (st_reg == S_BIQ |-> blk.ntap == 5'h00 && $past(st_reg) inside {S_IIR, S_BIQ})
    else $error("biquad with fir or without iir");
  coef_store_a: assert property (coef_we |=> coef_mem[$past(coef_addr)] == $past(coef_data))
    else $error("coefficient not stored");
  mute_zero_a: assert property (st_reg == S_GAIN && mute_c |=> gain_reg == 16'sh0000 && st_reg == S_OUT)
    else $error("muted sample not zero");
endmodule

/* testbench/pmd_mic_model.sv */
// behavioural pair of pdm microphones feeding the record path
// assumes one core clock; bits change a fixed delay after the rising edge
module pmd_mic_model #(
  parameter int TICK = 3                  // core cycles per mic bit
) (
  input  wire logic       core_clk,       // core clock
  input  wire logic       rst,            // synchronous reset
  input  wire logic [1:0] mode,           // 0 ones, 1 zeros, else random density
  output logic            pdm_l,          // left mic bit
  output logic            pdm_r,          // right mic bit
  output logic            pdm_tick        // one strobe per mic bit
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  int seed;
  initial begin
    cnt      = 0;
    seed     = 32'h0663;
    pdm_l    = 1'b0;
    pdm_r    = 1'b0;
    pdm_tick = 1'b0;
  end
  // sparse strobe: dense ticks starve the shared filter sequencer
  always @(posedge core_clk) begin
    #10;
    cnt      = (rst || cnt == TICK - 1) ? 0 : cnt + 1;
    pdm_tick = !rst && cnt == 0;
    if (cnt == 0) begin
      pdm_l = (mode == 2'h0) ? 1'b1 : (mode == 2'h1) ? 1'b0 : 1'($random(seed));
      pdm_r = (mode == 2'h0) ? 1'b1 : (mode == 2'h1) ? 1'b0 : 1'($random(seed));
    end
  end
endmodule

/* testbench/pmd_record_bench.sv */
// self-checking bench for the pdm record path
// assumes the mic model drives the pins and the bench drives all controls
module pmd_record_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, pdm_l, pdm_r, pdm_tick, power_l = 1'b1, power_r = 1'b1;
  logic [4:0] block_sel = 5'h01;
  logic [1:0] osr = 2'h0, mode = 2'h0;
  logic [2:0] fine_l = 3'h0, fine_r = 3'h0;
  logic signed [5:0] vol_l = 6'h00, vol_r = 6'h00;
  logic mute_l = 1'b0, mute_r = 1'b0, coef_we = 1'b0, out_valid, out_ready = 1'b1, cfg_error;
  logic [5:0] coef_addr = 6'h00;
  logic signed [15:0] coef_data = 16'h0000;
  pmd_pkg::pmd_sample_t out_word, w0;
  int err_count = 0, cmp_count = 0, seed = 32'h0663, b, o, v, f, i;
  always #50 core_clk = ~core_clk;
  pmd_mic_model mic (.core_clk(core_clk), .rst(rst), .mode(mode), .pdm_l(pdm_l), .pdm_r(pdm_r),
    .pdm_tick(pdm_tick));
  pmd_record dut (.core_clk(core_clk), .rst(rst), .ce(ce), .pdm_l(pdm_l), .pdm_r(pdm_r), .pdm_tick(pdm_tick),
    .block_sel(block_sel), .decimation_oversampling_ratio(osr), .power_l(power_l), .power_r(power_r),
    .fine_l(fine_l), .fine_r(fine_r), .vol_l(vol_l), .vol_r(vol_r), .mute_l(mute_l), .mute_r(mute_r),
    .coef_we(coef_we), .coef_addr(coef_addr), .coef_data(coef_data), .out_word(out_word),
    .out_valid(out_valid), .out_ready(out_ready), .cfg_error(cfg_error));
  task automatic close_out();
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic bad(input string msg);
    err_count++;
    $display("BAD %0t %s", $time, msg);
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) bad("flag differs");
  endtask
  task automatic cmp_near(input logic signed [15:0] got, input int exp);
    int tol;
    tol = (exp == 0) ? 0 : ((exp < 0 ? -exp : exp) / 32 + 40);
    cmp_count++;
    if ($isunknown(got) || int'(got) - exp > tol || exp - int'(got) > tol) bad("sample off");
  endtask
  // expected legality of an oversampling ratio for a block number
  function automatic logic exp_ok(input int bn, input int on);
    int g;
    g = (bn < 1 || bn > 18) ? 0 : (bn - 1) / 6;
    return (g == 0) ? (on == 0 || on == 1) : (g == 1) ? (on == 1) : (on == 2);
  endfunction
  // full-scale level after volume and fine gain, clipped at the top
  function automatic int exp_gain(input int vd, input int fd);
    real r;
    r = 32767.0 * $pow(10.0, (vd - 0.1 * fd) / 20.0);
    return (r > 32767.0) ? 32767 : int'(r);
  endfunction
  task automatic wcoef(input int a, input logic signed [15:0] d);
    coef_we   = 1'b1;
    coef_addr = 6'(a);
    coef_data = d;
    @(posedge core_clk);
    #10 coef_we = 1'b0;
    @(posedge core_clk);
    #10;
  endtask
  // one accepted word; a random ready models a stalling receiver
  task automatic get_word(output pmd_pkg::pmd_sample_t w, input bit stall);
    int k;
    bit got;
    for (k = 0; k < 3000; k++) begin
      out_ready = stall ? 1'($random(seed)) : 1'b1;
      got = (out_valid === 1'b1 && out_ready === 1'b1);
      if (got) w = out_word;
      @(posedge core_clk);
      #10;
      if (got) return;
    end
    bad("no output word");
    close_out();
  endtask
  // drop settling words, then check channel order and levels
  task automatic stream(input int n, input bit wl, wr, ckl, ckr, input int el, er, input bit stall);
    pmd_pkg::pmd_sample_t w;
    logic last;
    int k;
    for (k = 0; k < 10; k++) get_word(w, stall);
    last = w.right;
    for (k = 0; k < n; k++) begin
      get_word(w, stall);
      cmp_bit(w.right ? wr : wl, 1'b1);
      if (wl && wr) cmp_bit(w.right, ~last);
      if (w.right ? ckr : ckl) cmp_near(w.data, w.right ? er : el);
      last = w.right;
    end
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    #10 rst = 1'b0;
    cmp_bit(out_valid, 1'b0);
    @(posedge core_clk);
    #10 cmp_bit(cfg_error, 1'b0);
    // unity iir, every biquad b0 and fir tap0, everything else zero
    for (i = 0; i < 53; i++)
      wcoef(i, (i == 0 || i == 28 || (i >= 3 && i < 28 && (i - 3) % 5 == 0)) ? 16'sh4000 : 16'sh0000);
    for (b = 0; b < 20; b++) for (o = 0; o < 4; o++) begin
      block_sel = 5'(b);
      osr = 2'(o);
      repeat (2) @(posedge core_clk);
      #10 cmp_bit(cfg_error, ~exp_ok(b, o));
    end
    // every block passes full scale; right-only blocks drop the left word
    for (b = 1; b < 19; b++) begin
      block_sel = 5'(b);
      osr = ((b - 1) / 6 == 0) ? pmd_pkg::OSR_128 : ((b - 1) / 6 == 1) ? pmd_pkg::OSR_64 : pmd_pkg::OSR_32;
      stream(4, ((b - 1) % 6) < 3, 1, 1, 1, 32767, 32767, 0);
      cmp_bit(cfg_error, 1'b0);
    end
    // halving the iir b0, the first biquad b0 or fir tap0 halves the output
    for (b = 1; b < 4; b++) begin
      block_sel = 5'(b);
      osr = pmd_pkg::OSR_64;
      i = (b == 1) ? 0 : (b == 2) ? 3 : 28;
      wcoef(i, 16'sh2000);
      stream(4, 1, 1, 1, 1, 16383, 16383, 0);
      wcoef(i, 16'sh4000);
    end
    block_sel = 5'h07;
    // volume and fine gain: corners first, then random settings
    for (i = 0; i < 8; i++) begin
      v = (i == 0) ? -12 : (i == 1) ? 20 : (i == 2) ? 0 : int'($unsigned($random(seed)) % 33) - 12;
      f = (i < 2) ? 0 : (i == 2) ? 4 : int'($unsigned($random(seed)) % 5);
      vol_l = 6'(v);
      fine_l = 3'(f);
      vol_r = 6'(-v / 2);
      fine_r = 3'(4 - f);
      stream(4, 1, 1, 1, 1, exp_gain(v, f), exp_gain(-v / 2, 4 - f), 0);
    end
    {vol_l, vol_r, fine_l, fine_r} = '0;
    power_l = 1'b0;
    stream(4, 0, 1, 1, 1, 32767, 32767, 0);
    {power_l, power_r} = 2'b10;
    stream(4, 1, 0, 1, 1, 32767, 32767, 0);
    power_r = 1'b1;
    // random mic data under a stalling receiver, left muted
    mode = 2'h2;
    mute_l = 1'b1;
    stream(12, 1, 1, 1, 0, 0, 0, 1);
    // long stall: the head word stays offered unchanged
    out_ready = 1'b0;
    repeat (500) @(posedge core_clk);
    #10 w0 = out_word;
    cmp_bit(out_valid, 1'b1);
    repeat (400) @(posedge core_clk);
    #10 cmp_bit(out_word === w0, 1'b1);
    cmp_bit(out_valid, 1'b1);
    mode = 2'h1;
    mute_l = 1'b0;
    stream(4, 1, 1, 1, 1, -32768, -32768, 0);
    close_out();
  end
endmodule
